// File: fsc_host_model.sv
// Host controller model: frames commands on the serial link, mode 0.
// Assumes mclk at 40 MHz; sclk phases of five mclk, idle low.
`timescale 1ns/100ps
module fsc_host_model (
	// Clock
	input  wire logic        mclk,
	// Serial link
	output logic             cs_n,
	output logic             sclk,
	output logic             si,
	input  wire logic        so,
	input  wire logic        so_oe,
	// Received bytes
	output logic [7:0]       rx_data,
	output logic             rx_oe,
	output logic             rx_stb
);
	// ==========================================
	// Idle levels
	initial begin
		cs_n    = 1'b1;
		sclk    = 1'b0;
		si      = 1'b0;
		rx_data = 8'h00;
		rx_oe   = 1'b0;
		rx_stb  = 1'b0;
	end

	// ==========================================
	// One framed command: nb bits out, nrd bytes back
	task automatic frame(input logic [31:0] d, input int nb, input int nrd);
		logic [7:0] b;
		logic       ok;
		b = 8'h00;
		@(negedge mclk);
		cs_n = 1'b0;
		repeat (5) @(negedge mclk);
		for (int i = nb - 1; i >= 0; i--) begin
			si = d[i];
			repeat (5) @(negedge mclk);
			sclk = 1'b1;
			repeat (5) @(negedge mclk);
			sclk = 1'b0;
		end
		// Released data line shows no stale value
		si = ~si;
		for (int k = 0; k < nrd; k++) begin
			ok = 1'b1;
			for (int j = 0; j < 8; j++) begin
				repeat (5) @(negedge mclk);
				sclk = 1'b1;
				b    = {b[6:0], so};
				ok   = ok & so_oe;
				repeat (5) @(negedge mclk);
				sclk = 1'b0;
			end
			rx_data = b;
			rx_oe   = ok;
			rx_stb  = 1'b1;
			@(negedge mclk);
			rx_stb  = 1'b0;
		end
		repeat (5) @(negedge mclk);
		cs_n = 1'b1;
		repeat (8) @(negedge mclk);
	endtask
endmodule

// File: fsc_link_if.sv
// Synchronised serial link events passed from pin sync to the core.
// Assumes all members are in the mclk domain.
`timescale 1ns/100ps
interface fsc_link_if;
	logic cs_n;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic si;
	modport sync (output cs_n, cs_rise, sclk_rise, sclk_fall, si);
	modport core (input cs_n, cs_rise, sclk_rise, sclk_fall, si);
endinterface

// File: fsc_pin_sync.sv
// Two-stage synchronisers and edge detect for the serial pins.
// Assumes sclk well below mclk/8 so no edge is missed.
`timescale 1ns/100ps
module fsc_pin_sync (
	// Clock and reset
	input  wire logic  mclk,
	input  wire logic  rstn,
	// Pins
	input  wire logic  cs_n_pin,
	input  wire logic  sclk_pin,
	input  wire logic  si_pin,
	// Events
	fsc_link_if.sync   lnk
);
	logic [2:0] cs_q;
	logic [2:0] ck_q;
	logic [1:0] si_q;

	// ==========================================
	// Synchronisers, third stage for edges
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cs_q <= 3'h7;
			ck_q <= 3'h0;
			si_q <= 2'h0;
		end else begin
			cs_q <= {cs_q[1:0], cs_n_pin};
			ck_q <= {ck_q[1:0], sclk_pin};
			si_q <= {si_q[0], si_pin};
		end
	end

	assign lnk.cs_n      = cs_q[1];
	assign lnk.cs_rise   = cs_q[1] & ~cs_q[2];
	assign lnk.sclk_rise = ck_q[1] & ~ck_q[2] & ~cs_q[1];
	assign lnk.sclk_fall = ~ck_q[1] & ck_q[2] & ~cs_q[1];
	assign lnk.si        = si_q[1];
endmodule

// File: fsc_pkg.sv
// Constants shared by the flash status/config/id command logic.
// Assumes a 40 MHz mclk; all values are plain package constants.
package fsc_pkg;
	// ==========================================
	// Clock and timing
	localparam int CLK_MHZ              = 40;
	localparam int STATUS_WRITE_TIME_US = 5000;
	localparam int STATUS_WRITE_CYCLES  = STATUS_WRITE_TIME_US * CLK_MHZ;
	// ==========================================
	// Opcodes
	localparam logic [7:0] OPC_READ_ID     = 8'h90;
	localparam logic [7:0] OPC_READ_STATUS = 8'h05;
	localparam logic [7:0] OPC_READ_CONFIG = 8'h15;
	localparam logic [7:0] OPC_WRITE_STAT  = 8'h01;
	localparam logic [7:0] OPC_WR_ENABLE   = 8'h06;
	localparam logic [7:0] OPC_WR_DISABLE  = 8'h04;
	localparam logic [7:0] ID_ADDR_DEVICE  = 8'h01;
	// ==========================================
	// Status and config field positions
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WEL_BIT  = 1;
	localparam int ST_BP_LSB   = 2;
	localparam int ST_BP_MSB   = 5;
	localparam int ST_QE_BIT   = 6;
	localparam int CF_TB_BIT   = 3;
	localparam logic [3:0] BP_RESET = 4'h0;
	localparam logic       TB_RESET = 1'b0;
	localparam int ID_PAD_BYTES = 2;
	// ==========================================
	// Command states
	typedef enum logic [3:0] {
		FSC_OPC, FSC_ADDR, FSC_ID, FSC_STAT, FSC_CFG,
		FSC_WDATA, FSC_WEN, FSC_WDI, FSC_SKIP
	} fsc_state_t;
endpackage

// File: fsc_top.sv
// Serial flash command logic: id read, status/config read and write.
// Assumes host drives mode-0 framing, sclk slow against mclk,
// and array logic reports program/erase requests on mclk.
// Summary of operation
// - Id read: opcode, two dummy bytes, address byte, then output.
// - Id bytes leave on falling sclk, most significant bit first.
// - Address 00h gives maker first; 01h gives device first.
// - Maker and device codes alternate until chip select rises.
// - Status read accepted any time, even while busy.
// - Config read accepted any time, even while busy.
// - Busy bit set during program, erase or status write.
// - Write commands accepted only with write-enable latch set.
// - Program or erase into protected area is ignored.
// - Four protect bits reset zero, changed only by status write.
// - Protect guards program/erase; chip erase only with zero level.
// - Quad enable bit reads one always; bit7 reserved.
// - Top/bottom bit is one-time set by status write; default top.
// - Status write needs latch set beforehand.
// - First byte status, optional second config; latch and busy untouched.
// - Chip select must rise after exactly 8 or 16 data bits.
// - Valid write starts timed cycle; end clears busy and latch.
// - Opcode 15h reads the config byte.
// - Opcode 01h is status write with one or two bytes.
// - Framed write-enable sets the latch.
// - Latch cleared at reset, write-disable, write, program, erase.
`timescale 1ns/100ps
module fsc_top
	import fsc_pkg::*;
#(
	parameter int         WR_CYCLES  = STATUS_WRITE_CYCLES,
	parameter logic [7:0] MAKER_CODE = 8'h5A,  // Arbitrary value
	parameter logic [7:0] DEV_CODE   = 8'hA5   // Arbitrary value
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Serial link pins
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        si,
	output logic             so,
	output logic             so_oe,
	// Array program/erase handshake
	input  wire logic        array_op_req,
	input  wire logic        array_op_chip,
	input  wire logic        array_op_protected,
	input  wire logic        array_op_done,
	output logic             array_op_go,
	// Protection settings
	output logic [3:0]       block_protect,
	output logic             top_bottom_select
);
	fsc_link_if lnk ();
	fsc_state_t st_q;
	logic [2:0] bit_cnt_q;
	logic [1:0] byte_cnt_q;
	logic [2:0] out_cnt_q;
	logic [6:0] rx_q;
	logic [7:0] rx_byte;
	logic       byte_done;
	logic       id_sel_q;
	logic       wel_q;
	logic       arr_busy_q;
	logic       busy;
	logic [3:0] bp_q;
	logic       tb_q;
	logic [7:0] wsr_st_q;
	logic       wsr_tb_q;
	logic       wsr_has_cfg_q;
	logic       tmr_start;
	logic       tmr_busy;
	logic       tmr_done;
	logic       arr_ok;
	logic [7:0] status_byte;
	logic [7:0] config_byte;
	logic [7:0] out_byte;

	fsc_pin_sync u_sync (
		.mclk     (mclk),
		.rstn     (rstn),
		.cs_n_pin (cs_n),
		.sclk_pin (sclk),
		.si_pin   (si),
		.lnk      (lnk.sync)
	);

	fsc_wr_timer #(.CYCLES(WR_CYCLES)) u_tmr (
		.mclk  (mclk),
		.rstn  (rstn),
		.start (tmr_start),
		.busy  (tmr_busy),
		.done  (tmr_done)
	);

	// ==========================================
	// Register views
	assign busy        = tmr_busy | arr_busy_q;
	assign status_byte = {1'b0, 1'b1, bp_q, wel_q, busy};
	assign config_byte = {4'h0, tb_q, 3'h0};
	assign rx_byte     = {rx_q, lnk.si};
	assign byte_done   = lnk.sclk_rise && bit_cnt_q == 3'h7;

	always_comb begin
		case (st_q)
			FSC_STAT: out_byte = status_byte;
			FSC_CFG:  out_byte = config_byte;
			FSC_ID:   out_byte = id_sel_q ? DEV_CODE : MAKER_CODE;
			default:  out_byte = 8'h00;
		endcase
	end

	// ==========================================
	// Input shifting
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_q <= 3'h0;
			rx_q      <= 7'h00;
		end else if (lnk.cs_n) begin
			bit_cnt_q <= 3'h0;
		end else if (lnk.sclk_rise) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			rx_q      <= rx_byte[6:0];
		end
	end

	// ==========================================
	// Command decode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q          <= FSC_OPC;
			byte_cnt_q    <= 2'h0;
			id_sel_q      <= 1'b0;
			wsr_st_q      <= 8'h00;
			wsr_tb_q      <= 1'b0;
			wsr_has_cfg_q <= 1'b0;
		end else if (lnk.cs_n) begin
			st_q       <= FSC_OPC;
			byte_cnt_q <= 2'h0;
		end else if (lnk.sclk_rise) begin
			case (st_q)
				FSC_OPC: begin
					if (byte_done) begin
						if (rx_byte == OPC_READ_STATUS) begin
							st_q <= FSC_STAT;
						end else if (rx_byte == OPC_READ_CONFIG) begin
							st_q <= FSC_CFG;
						end else if (busy) begin
							st_q <= FSC_SKIP;
						end else if (rx_byte == OPC_READ_ID) begin
							st_q <= FSC_ADDR;
						end else if (rx_byte == OPC_WRITE_STAT) begin
							st_q <= FSC_WDATA;
						end else if (rx_byte == OPC_WR_ENABLE) begin
							st_q <= FSC_WEN;
						end else if (rx_byte == OPC_WR_DISABLE) begin
							st_q <= FSC_WDI;
						end else begin
							st_q <= FSC_SKIP;
						end
					end
				end
				FSC_ADDR: begin
					if (byte_done) begin
						byte_cnt_q <= byte_cnt_q + 2'h1;
						if (byte_cnt_q == 2'(ID_PAD_BYTES)) begin
							id_sel_q <= rx_byte == ID_ADDR_DEVICE;
							st_q     <= FSC_ID;
						end
					end
				end
				FSC_WDATA: begin
					if (byte_done) begin
						byte_cnt_q <= byte_cnt_q + 2'h1;
						if (byte_cnt_q == 2'h0) begin
							wsr_st_q      <= rx_byte;
							wsr_has_cfg_q <= 1'b0;
						end else if (byte_cnt_q == 2'h1) begin
							wsr_tb_q      <= rx_byte[CF_TB_BIT];
							wsr_has_cfg_q <= 1'b1;
						end else begin
							st_q <= FSC_SKIP;
						end
					end
				end
				FSC_WEN, FSC_WDI: st_q <= FSC_SKIP;
				default: st_q <= st_q;
			endcase
		end else if (lnk.sclk_fall && st_q == FSC_ID && out_cnt_q == 3'h7) begin
			id_sel_q <= ~id_sel_q;
		end
	end

	// ==========================================
	// Output shifting on falling sclk
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			out_cnt_q <= 3'h0;
			so        <= 1'b0;
			so_oe     <= 1'b0;
		end else if (lnk.cs_n) begin
			out_cnt_q <= 3'h0;
			so_oe     <= 1'b0;
		end else if (lnk.sclk_fall && (st_q == FSC_STAT || st_q == FSC_CFG || st_q == FSC_ID)) begin
			so        <= out_byte[~out_cnt_q];
			so_oe     <= 1'b1;
			out_cnt_q <= out_cnt_q + 3'h1;
		end
	end

	// ==========================================
	// Status write start at chip select rise, commit at timer done
	assign tmr_start = lnk.cs_rise && st_q == FSC_WDATA && wel_q && !busy
		&& bit_cnt_q == 3'h0 && byte_cnt_q != 2'h0;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bp_q <= BP_RESET;
			tb_q <= TB_RESET;
		end else if (tmr_done) begin
			bp_q <= wsr_st_q[ST_BP_MSB:ST_BP_LSB];
			if (wsr_has_cfg_q) begin
				tb_q <= tb_q | wsr_tb_q;
			end
		end
	end

	// ==========================================
	// Write-enable latch
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wel_q <= 1'b0;
		end else begin
			if (tmr_done || array_op_done) begin
				wel_q <= 1'b0;
			end
			if (lnk.cs_rise && st_q == FSC_WDI && bit_cnt_q == 3'h0) begin
				wel_q <= 1'b0;
			end
			if (lnk.cs_rise && st_q == FSC_WEN && bit_cnt_q == 3'h0) begin
				wel_q <= 1'b1;
			end
		end
	end

	// ==========================================
	// Array program/erase gating
	// Latch is being cleared by a finishing write cycle
	assign arr_ok = wel_q && !busy && !tmr_done
		&& (array_op_chip ? bp_q == 4'h0 : !array_op_protected);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			arr_busy_q  <= 1'b0;
			array_op_go <= 1'b0;
		end else begin
			array_op_go <= array_op_req && arr_ok;
			if (array_op_req && arr_ok) begin
				arr_busy_q <= 1'b1;
			end else if (array_op_done) begin
				arr_busy_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			block_protect     <= BP_RESET;
			top_bottom_select <= TB_RESET;
		end else begin
			block_protect     <= bp_q;
			top_bottom_select <= tb_q;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_wr_commit;
		lnk.cs_rise && st_q == FSC_WDATA && !busy;
	endsequence

	property p_busy_on_start;
		tmr_start |=> busy [*3];
	endproperty
	a_busy_on_start: assert property (p_busy_on_start) else $error("busy not set");

	property p_done_clears;
		tmr_done |=> !wel_q && !busy;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("latch or busy left");

	property p_need_wel;
		s_wr_commit ##0 !wel_q |=> !tmr_busy;
	endproperty
	a_need_wel: assert property (p_need_wel) else $error("write without latch");

	property p_exact_bits;
		s_wr_commit ##0 bit_cnt_q != 3'h0 |=> !tmr_busy;
	endproperty
	a_exact_bits: assert property (p_exact_bits) else $error("partial byte accepted");

	property p_fixed_bits;
		status_byte[ST_QE_BIT] && !status_byte[7] && config_byte[2:0] == 3'h0;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits wrong");

	property p_chip_guard;
		array_op_req && array_op_chip && bp_q != 4'h0 |=> !array_op_go;
	endproperty
	a_chip_guard: assert property (p_chip_guard) else $error("chip erase not blocked");

	property p_area_guard;
		array_op_req && !array_op_chip && array_op_protected |=> !array_op_go;
	endproperty
	a_area_guard: assert property (p_area_guard) else $error("protected op allowed");

	property p_bp_load;
		tmr_done |=> bp_q == $past(wsr_st_q[ST_BP_MSB:ST_BP_LSB]) && !wel_q;
	endproperty
	a_bp_load: assert property (p_bp_load) else $error("protect not loaded");

	property p_stat_bit;
		lnk.sclk_fall && !lnk.cs_n && st_q == FSC_STAT |=> so == $past(status_byte[~out_cnt_q]) && so_oe;
	endproperty
	a_stat_bit: assert property (p_stat_bit) else $error("status bit wrong");

	property p_quiet;
		lnk.cs_n |=> !so_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("output driven deselected");
endmodule

// File: fsc_wr_timer.sv
// Self-timed register write cycle counter.
// Assumes start is a one-cycle pulse, ignored while busy.
`timescale 1ns/100ps
module fsc_wr_timer #(
	parameter int CYCLES = 200000
) (
	// Clock and reset
	input  wire logic  mclk,
	input  wire logic  rstn,
	// Control
	input  wire logic  start,
	output logic       busy,
	output logic       done
);
	logic [31:0] cnt_q;

	// ==========================================
	// Countdown
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 32'h0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy  <= 1'b1;
				cnt_q <= 32'(CYCLES - 1);
			end else if (busy) begin
				if (cnt_q == 32'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 32'h1;
				end
			end
		end
	end
endmodule

// File: test_flash_status_config_id_readout.sv
// Self-checking bench for the flash status/config/id command logic.
// Assumes the host model and design package are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module test_flash_status_config_id_readout;
	import fsc_pkg::*;
	localparam int         WRC = 400;
	localparam logic [7:0] MK  = 8'h3C;  // Arbitrary value
	localparam logic [7:0] DV  = 8'h96;  // Arbitrary value
	logic       mclk, rstn, cs_n, sclk, si, so, so_oe;
	logic       req, chip, prot, done, go, tbs, rx_oe, rx_stb;
	logic [3:0] bp;
	logic [7:0] rx_data, e, d;
	logic [7:0] expq[$];
	int         errors = 0;
	int         samples_checked = 0;
	logic       polling = 1'b0;

	// ==========================================
	// Clock, instances
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	fsc_top #(.WR_CYCLES(WRC), .MAKER_CODE(MK), .DEV_CODE(DV)) fsc_top_inst (
		.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
		.array_op_req(req), .array_op_chip(chip), .array_op_protected(prot),
		.array_op_done(done), .array_op_go(go), .block_protect(bp), .top_bottom_select(tbs));
	fsc_host_model fsc_host_model_inst (
		.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
		.rx_data(rx_data), .rx_oe(rx_oe), .rx_stb(rx_stb));

	// ==========================================
	// Closing report
	task automatic summarize;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================
	// Result monitor
	always @(posedge rx_stb) begin
		if (!polling) begin
			if (expq.size() == 0) begin
				errors++;
				$display("mismatch rx_data exp none got %h", rx_data);
			end else begin
				e = expq.pop_front();
				`CHK("rx_data", e, rx_data)
				`CHK("rx_oe", 1'b1, rx_oe)
			end
		end
	end

	initial begin
		repeat (100000) @(posedge mclk);
		errors++;
		$display("mismatch watchdog exp done got hang");
		summarize();
	end

	// ==========================================
	// Command helpers
	task automatic rd(input logic [7:0] op, input logic [7:0] x, input int n);
		repeat (n) expq.push_back(x);
		fsc_host_model_inst.frame({24'h000000, op}, 8, n);
	endtask
	task automatic idrd(input logic [7:0] a, input logic [7:0] f, input logic [7:0] s);
		expq.push_back(f);
		expq.push_back(s);
		expq.push_back(f);
		fsc_host_model_inst.frame({OPC_READ_ID, 16'h0000, a}, 32, 3);
	endtask
	task automatic wr(input logic [31:0] x, input int nb);
		fsc_host_model_inst.frame(x, nb, 0);
	endtask
	// Poll status until busy clears, then confirm latch clear
	task automatic poll;
		logic b;
		b       = 1'b1;
		polling = 1'b1;
		for (int k = 0; k < 20 && b; k++) begin
			fsc_host_model_inst.frame({24'h000000, OPC_READ_STATUS}, 8, 1);
			b = rx_data[ST_BUSY_BIT] !== 1'b0;
		end
		polling = 1'b0;
		`CHK("write_busy", 1'b0, rx_data[ST_BUSY_BIT])
		`CHK("write_enable_latch", 1'b0, rx_data[ST_WEL_BIT])
	endtask
	task automatic arr(input logic c, input logic p, input int x);
		int n;
		n = 0;
		@(negedge mclk);
		req  = 1'b1;
		chip = c;
		prot = p;
		repeat (4) begin
			@(negedge mclk);
			req = 1'b0;
			if (go !== 1'b0) n++;
		end
		`CHK("array_op_go", x, n)
	endtask

	// ==========================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		req  = 1'b0;
		chip = 1'b0;
		prot = 1'b0;
		done = 1'b0;
		void'($urandom(32'h172c6906));
		repeat (20) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		rd(OPC_READ_STATUS, 8'h40, 2);
		rd(OPC_READ_CONFIG, 8'h00, 1);
		idrd(8'h00, MK, DV);
		idrd(8'h01, DV, MK);
		idrd(8'($urandom_range(2, 255)), MK, DV);
		wr({16'h0000, OPC_WRITE_STAT, 8'hFF}, 16);
		rd(OPC_READ_STATUS, 8'h40, 1);
		wr({24'h000000, OPC_WR_ENABLE}, 8);
		rd(OPC_READ_STATUS, 8'h42, 1);
		wr({24'h000000, OPC_WR_DISABLE}, 8);
		rd(OPC_READ_STATUS, 8'h40, 1);
		wr({24'h000000, OPC_WR_ENABLE}, 8);
		wr({15'h0000, OPC_WRITE_STAT, 9'h1FF}, 17);
		rd(OPC_READ_STATUS, 8'h42, 1);
		d = 8'($urandom) | 8'h04;
		wr({16'h0000, OPC_WRITE_STAT, d}, 16);
		rd(OPC_READ_STATUS, 8'h43, 1);
		rd(OPC_READ_CONFIG, 8'h00, 1);
		poll();
		rd(OPC_READ_STATUS, 8'h40 | (d & 8'h3C), 1);
		`CHK("block_protect", d[5:2], bp)
		wr({24'h000000, OPC_WR_ENABLE}, 8);
		arr(1'b1, 1'b0, 0);
		arr(1'b0, 1'b1, 0);
		arr(1'b0, 1'b0, 1);
		rd(OPC_READ_STATUS, 8'h43 | (d & 8'h3C), 1);
		@(negedge mclk);
		done = 1'b1;
		@(negedge mclk);
		done = 1'b0;
		repeat (2) @(negedge mclk);
		rd(OPC_READ_STATUS, 8'h40 | (d & 8'h3C), 1);
		arr(1'b0, 1'b0, 0);
		wr({24'h000000, OPC_WR_ENABLE}, 8);
		wr({8'h00, OPC_WRITE_STAT, 8'h00, 8'hFF}, 24);
		poll();
		rd(OPC_READ_CONFIG, 8'h08, 1);
		rd(OPC_READ_STATUS, 8'h40, 1);
		`CHK("top_bottom_select", 1'b1, tbs)
		`CHK("block_protect", 4'h0, bp)
		`CHK("pending", 0, expq.size())
		summarize();
	end
endmodule
